// >>> rtl/svmon_ioseg.sv
// svmon_ioseg: terminal states to top and bottom segment patterns
`timescale 1ns/10ps
`default_nettype none
module svmon_ioseg #(
	parameter int unsigned N = 7 // terminals per monitor
) (
	input wire logic [N-1:0] closed, // 1 = terminal shorted (on)
	output logic [N-1:0] seg_top, // top segment lit: open
	output logic [N-1:0] seg_bot // bottom segment lit: shorted
);
	// one display position per terminal
	for (genvar i = 0; i < N; i++) begin : g_pos
		assign seg_top[i] = ~closed[i];
		assign seg_bot[i] = closed[i];
	end
endmodule // svmon_ioseg
`default_nettype wire

// >>> rtl/svmon_key.sv
// svmon_key: key synchroniser, press detector and long-hold detector
`timescale 1ns/10ps
`default_nettype none
module svmon_key #(
	parameter int unsigned N = 5, // number of keys
	parameter int unsigned HOLD_CYC = 10_000_000, // hold time in cycles
	parameter int unsigned HOLD_KEY = 4 // key with long-hold detection
) (
	input wire logic clk, // panel clock
	input wire logic rst_sync_n, // synchronised reset, low active
	input wire logic [N-1:0] key_pin, // raw keys, high while pressed
	output logic [N-1:0] press, // one-cycle pulse on press
	output logic hold // one-cycle pulse once the hold time is reached
);
	typedef struct packed {
		logic [N-1:0] s1; // first synchroniser stage
		logic [N-1:0] s2; // second synchroniser stage
		logic [N-1:0] prev; // last settled level
		logic [31:0] cnt; // hold counter
		logic done; // hold already reported
	} svmon_key_st_t;
	svmon_key_st_t st_ff;
	svmon_key_st_t nxt_st;
	// press pulses compare the second stage with the last settled level
	assign press = st_ff.s2 & ~st_ff.prev;
	assign hold = st_ff.s2[HOLD_KEY] && !st_ff.done &&
		(st_ff.cnt == 32'(HOLD_CYC - 1));
	// next state: shift in, count the hold key while it stays down
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = key_pin;
		nxt_st.s2 = st_ff.s1;
		nxt_st.prev = st_ff.s2;
		if (!st_ff.s2[HOLD_KEY]) begin
			// released: rearm the hold detector
			nxt_st.cnt = 32'h0000_0000;
			nxt_st.done = 1'b0;
		end else if (hold) begin
			nxt_st.done = 1'b1; // one report per hold
		end else if (!st_ff.done) begin
			nxt_st.cnt = st_ff.cnt + 32'h0000_0001;
		end
	end
	// state register
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
endmodule // svmon_key
`default_nettype wire

// >>> rtl/svmon_panel.sv
// svmon_panel: monitor mode of the servo amplifier operator panel
// Function
// - monitor entered and refreshed while motor runs
// - items 000 to 00D plus 010, 011
// - speed reference valid only in speed control
// - pulse speed, error, reference count: position control
// - load rates averaged over ten seconds, percent
// - angle 1 unavailable without scale zero mark
// - angle 1 as 32-bit decimal pulse count
// - angle 2 in degrees from phase U
// - pulse counters 32-bit, shown in hex
// - item 010 shows speed limit or ratio
// - input open lights top, shorted lights bottom
// - seven input positions, one per terminal
// - output open lights top, shorted lights bottom
// - seven output positions, alarm first, codes last
// - output segment on at low signal level
// - mode key enters, up/down step items
// - enter press or one-second shift toggles value
// - counters show upper half first, up/down swaps
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/10ps
`default_nettype none
module svmon_panel #(
	parameter int unsigned HOLD_CYC = svmon_pkg::SHIFT_HOLD_CYC, // shift hold
	parameter int unsigned LOAD_TICK = svmon_pkg::LOAD_TICK_CYC // load sample
) (
	input wire logic mclk, // panel clock, 10 MHz
	input wire logic rst_n, // asynchronous reset, low active
	input wire logic [4:0] key_pin, // mode, up, down, enter, shift keys
	input wire logic [6:0] in_term_on, // input terminals, 1 = shorted
	input wire logic [6:0] out_term_lvl, // output terminal levels, 1 = H
	input wire logic speed_mode, // drive in speed control
	input wire logic position_mode, // drive in position control
	input wire logic scale_zero_ok, // linear scale has a zero mark
	input wire logic [15:0] speed_act, // actual speed, mm/s
	input wire logic [15:0] speed_ref, // input speed reference, mm/s
	input wire logic [15:0] force_ref, // force reference, percent
	input wire logic [31:0] angle_pulses, // pulses from phase-C mark
	input wire logic [15:0] angle_deg, // degrees from phase U zero
	input wire logic [15:0] pulse_speed, // reference pulse speed, mm/s
	input wire logic [15:0] pos_error, // position error, reference units
	input wire logic [7:0] load_pct, // instantaneous force load, percent
	input wire logic [7:0] regen_pct, // instantaneous regen load, percent
	input wire logic [7:0] brake_pct, // instantaneous brake power, percent
	input wire logic [31:0] ref_count, // reference pulse counter
	input wire logic [31:0] fb_count, // feedback pulse counter
	input wire logic [15:0] speed_limit, // speed limit, 100 mm/s units
	input wire logic [15:0] divide_ratio, // ratio, pulses per scale pitch
	input wire logic [2:0] hall_pattern, // hall sensor pattern
	input wire logic [7:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after the strobe
	output logic mon_active, // monitor mode owns the display
	output logic [11:0] disp_code, // item code shown after the U prefix
	output logic [15:0] disp_data, // value shown
	output logic [1:0] disp_fmt, // format, see svmon_fmt_t
	output logic disp_valid, // item valid in present conditions
	output logic disp_upper, // 32-bit item shows its upper half
	output logic [6:0] seg_top, // top segments of terminal monitor
	output logic [6:0] seg_bot // bottom segments of terminal monitor
);
	// samples per window, log2
	localparam int unsigned LOAD_SAMPLES_LG = svmon_pkg::LOAD_SAMPLES_LG;
	typedef struct packed {
		svmon_pkg::svmon_state_t mode; // panel state
		logic act; // monitor mode active
		logic [3:0] idx; // selected item
		logic upper; // upper half of a 32-bit item
		logic alt; // ratio instead of speed limit
		logic [6:0] in_s1; // input terminal sync stage 1
		logic [6:0] in_s2; // input terminal sync stage 2
		logic [31:0] ctrl; // control register
		logic [31:0] tick; // load sample timer
		logic [LOAD_SAMPLES_LG+7:0] acc0; // load sum
		logic [LOAD_SAMPLES_LG+7:0] acc1; // regen sum
		logic [LOAD_SAMPLES_LG+7:0] acc2; // brake sum
		logic [LOAD_SAMPLES_LG-1:0] nsamp; // samples in this window
		logic [7:0] avg0; // load over last window
		logic [7:0] avg1; // regen over last window
		logic [7:0] avg2; // brake over last window
		logic [31:0] rdata; // read data
		logic [11:0] code; // shown code
		logic [15:0] data; // shown data
		svmon_pkg::svmon_fmt_t fmt; // shown format
		logic valid; // shown validity
		logic [6:0] top; // top segments
		logic [6:0] bot; // bottom segments
	} svmon_st_t;
	svmon_st_t st_ff;
	svmon_st_t nxt_st;
	logic [1:0] rst_sync_ff; // reset release synchroniser
	logic rst_sync_n; // synchronised reset
	logic [4:0] press; // key press pulses
	logic shift_hold; // shift key held long enough
	logic [6:0] io_closed; // terminal states of shown monitor
	logic [6:0] io_top; // top segment pattern
	logic [6:0] io_bot; // bottom segment pattern
	logic [15:0] load_word; // averaged rate of the shown load item
	// reset is asserted at once but released only after two edges
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_sync_ff[1];
	// keys: synchronised, edge detected, shift hold timed
	// no debounce: keys must be clean
	svmon_key #(
		.N(svmon_pkg::KEY_COUNT),
		.HOLD_CYC(HOLD_CYC),
		.HOLD_KEY(svmon_pkg::KEY_SHIFT)
	) u_key (
		.clk(mclk),
		.rst_sync_n(rst_sync_n),
		.key_pin(key_pin),
		.press(press),
		.hold(shift_hold)
	);
	// shown monitor picks input terminals or inverted output levels
	assign io_closed = (st_ff.idx == svmon_pkg::IDX_OUTMON) ?
		~out_term_lvl : st_ff.in_s2;
	svmon_ioseg #(
		.N(svmon_pkg::TERM_COUNT)
	) u_ioseg (
		.closed(io_closed),
		.seg_top(io_top),
		.seg_bot(io_bot)
	);
	// averaged load of the item under the cursor
	always_comb begin
		unique case (st_ff.idx)
			svmon_pkg::IDX_REGEN: load_word = {8'h00, st_ff.avg1};
			svmon_pkg::IDX_BRAKE: load_word = {8'h00, st_ff.avg2};
			default: load_word = {8'h00, st_ff.avg0};
		endcase
	end
	// next state: keys, load averaging, display, register port
	always_comb begin
		logic keys_on;
		logic toggle;
		logic wide;
		logic [15:0] hi_lo;
		logic [31:0] wide_val;
		keys_on = 1'b0;
		toggle = 1'b0;
		wide = 1'b0;
		hi_lo = 16'h0000;
		wide_val = 32'h0000_0000;
		nxt_st = st_ff;
		// input terminals pass two flops, then are read every cycle
		// a sub-cycle pulse can be missed
		nxt_st.in_s1 = in_term_on;
		nxt_st.in_s2 = st_ff.in_s1;
		keys_on = !st_ff.ctrl[svmon_pkg::CTRL_LOCK_BIT];
		toggle = press[svmon_pkg::KEY_ENTER] ||
			shift_hold;
		// 32-bit items
		wide = (st_ff.idx == svmon_pkg::IDX_ANG1) ||
			(st_ff.idx == svmon_pkg::IDX_REFCNT) ||
			(st_ff.idx == svmon_pkg::IDX_FBCNT);
		// key handling; no motor state is looked at, so entry works running
		// lock ignores all keys
		if (keys_on) begin
			unique case (st_ff.mode)
				svmon_pkg::SVMON_ST_OFF: begin
					// mode key wakes it
					if (press[svmon_pkg::KEY_MODE]) begin
						nxt_st.mode = svmon_pkg::SVMON_ST_NUM;
					end
				end
				svmon_pkg::SVMON_ST_NUM: begin
					if (press[svmon_pkg::KEY_MODE]) begin
						nxt_st.mode = svmon_pkg::SVMON_ST_OFF; // hand back
					end else if (toggle) begin
						nxt_st.mode = svmon_pkg::SVMON_ST_VAL;
						// upper half first
						nxt_st.upper = wide;
						nxt_st.alt = 1'b0; // speed limit first
					end else if (press[svmon_pkg::KEY_UP]) begin
						nxt_st.idx = st_ff.idx + 4'h1;
					end else if (press[svmon_pkg::KEY_DOWN]) begin
						nxt_st.idx = st_ff.idx - 4'h1;
					end
				end
				svmon_pkg::SVMON_ST_VAL: begin
					if (toggle) begin
						nxt_st.mode = svmon_pkg::SVMON_ST_NUM;
						nxt_st.upper = 1'b0;
					end else if (wide && (press[svmon_pkg::KEY_UP] ||
						press[svmon_pkg::KEY_DOWN])) begin
						nxt_st.upper = !st_ff.upper;
					end else if (press[svmon_pkg::KEY_MODE] &&
						st_ff.idx == svmon_pkg::IDX_SPDLIM) begin
						nxt_st.alt = !st_ff.alt;
					end
				end
				default: nxt_st.mode = svmon_pkg::SVMON_ST_OFF; // unused code
			endcase
		end
		// lags state like the display
		nxt_st.act = (st_ff.mode != svmon_pkg::SVMON_ST_OFF);
		// load averaging: 2^n samples evenly spaced over the window
		// steady input gives its exact mean
		if (st_ff.tick == 32'(LOAD_TICK - 1)) begin
			nxt_st.tick = 32'h0000_0000;
			nxt_st.nsamp = st_ff.nsamp + 1'b1;
			// trade-off: rate lags one window
			if (&st_ff.nsamp) begin
				// window closes: mean is the sum over the sample count
				nxt_st.avg0 = 8'((st_ff.acc0 + load_pct) >>
					LOAD_SAMPLES_LG);
				nxt_st.avg1 = 8'((st_ff.acc1 + regen_pct) >>
					LOAD_SAMPLES_LG);
				nxt_st.avg2 = 8'((st_ff.acc2 + brake_pct) >>
					LOAD_SAMPLES_LG);
				nxt_st.acc0 = '0;
				nxt_st.acc1 = '0;
				nxt_st.acc2 = '0;
			end else begin
				nxt_st.acc0 = st_ff.acc0 +
					load_pct;
				nxt_st.acc1 = st_ff.acc1 +
					regen_pct;
				nxt_st.acc2 = st_ff.acc2 +
					brake_pct;
			end
		end else begin
			nxt_st.tick = st_ff.tick + 32'h0000_0001;
		end
		// display: value inputs are re-read every cycle
		nxt_st.code = (st_ff.idx == svmon_pkg::IDX_SPDLIM) ?
			svmon_pkg::CODE_SPDLIM : ((st_ff.idx == svmon_pkg::IDX_HALL) ?
			svmon_pkg::CODE_HALL : {8'h00, st_ff.idx});
		// invalid items still show data
		nxt_st.valid = 1'b1;
		nxt_st.fmt = svmon_pkg::SVMON_FMT_DEC;
		nxt_st.data = 16'h0000;
		nxt_st.top = 7'h00;
		nxt_st.bot = 7'h00;
		unique case (st_ff.idx)
			svmon_pkg::IDX_SPEED: nxt_st.data = speed_act;
			svmon_pkg::IDX_SPDREF: begin
				nxt_st.data = speed_ref;
				nxt_st.valid = speed_mode;
			end
			svmon_pkg::IDX_FORCE: nxt_st.data = force_ref;
			svmon_pkg::IDX_ANG1: begin
				wide_val = angle_pulses;
				nxt_st.valid = scale_zero_ok;
			end
			svmon_pkg::IDX_ANG2: nxt_st.data = angle_deg;
			svmon_pkg::IDX_INMON, svmon_pkg::IDX_OUTMON: begin
				nxt_st.fmt = svmon_pkg::SVMON_FMT_SEG;
				nxt_st.top = io_top;
				nxt_st.bot = io_bot;
			end
			svmon_pkg::IDX_PULSPD: begin
				nxt_st.data = pulse_speed;
				nxt_st.valid = position_mode;
			end
			svmon_pkg::IDX_POSERR: begin
				nxt_st.data = pos_error;
				nxt_st.valid = position_mode;
			end
			svmon_pkg::IDX_LOAD, svmon_pkg::IDX_REGEN,
			svmon_pkg::IDX_BRAKE: nxt_st.data = load_word;
			svmon_pkg::IDX_REFCNT: begin
				wide_val = ref_count;
				nxt_st.fmt = svmon_pkg::SVMON_FMT_HEX;
				nxt_st.valid = position_mode;
			end
			svmon_pkg::IDX_FBCNT: begin
				wide_val = fb_count;
				nxt_st.fmt = svmon_pkg::SVMON_FMT_HEX;
			end
			svmon_pkg::IDX_SPDLIM: begin
				nxt_st.data = st_ff.alt ? divide_ratio :
					speed_limit;
			end
			svmon_pkg::IDX_HALL: nxt_st.data = {13'h0000, hall_pattern};
		endcase
		// 32-bit items are shown one half at a time
		hi_lo = st_ff.upper ? wide_val[31:16] :
			wide_val[15:0];
		if (wide) begin
			nxt_st.data = hi_lo;
		end
		if (st_ff.mode != svmon_pkg::SVMON_ST_VAL) begin
			nxt_st.fmt = svmon_pkg::SVMON_FMT_CODE; // number view
		end
		// register port: write, then read with one cycle of latency
		// other offsets are read-only
		if (reg_wr &&
			reg_addr == svmon_pkg::REG_CTRL) begin
			// only bit 0 is kept
			nxt_st.ctrl = {31'h0000_0000,
				reg_wdata[0]};
		end
		// data stand one cycle
		nxt_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				svmon_pkg::REG_CTRL: nxt_st.rdata = st_ff.ctrl;
				svmon_pkg::REG_STATUS: nxt_st.rdata = {22'h00_0000,
					st_ff.valid, st_ff.alt, st_ff.upper, st_ff.mode,
					1'b0, st_ff.idx};
				svmon_pkg::REG_DISP: nxt_st.rdata = {2'b00, st_ff.fmt,
					st_ff.code, st_ff.data};
				default: nxt_st.rdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end
	// state register
	// reset leaves the monitor off
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_ff <= '{mode: svmon_pkg::SVMON_ST_OFF,
				fmt: svmon_pkg::SVMON_FMT_CODE,
				ctrl: svmon_pkg::CTRL_RESET,
				default: '0};
		end else begin
			st_ff <= nxt_st;
		end
	end
	// outputs straight from flops
	// flop straight to pin
	assign reg_rdata = st_ff.rdata;
	assign mon_active = st_ff.act;
	assign disp_code = st_ff.code;
	assign disp_data = st_ff.data;
	assign disp_fmt = st_ff.fmt;
	assign disp_valid = st_ff.valid;
	assign disp_upper = st_ff.upper;
	assign seg_top = st_ff.top;
	assign seg_bot = st_ff.bot;
endmodule // svmon_panel
`default_nettype wire

// >>> rtl/svmon_pkg.sv
// svmon_pkg: constants and types shared by the servo monitor panel logic
package svmon_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 10_000_000; // mclk rate
	localparam int unsigned SHIFT_HOLD_MS = 1000; // least shift-key hold, ms
	localparam int unsigned SHIFT_HOLD_CYC = (CLK_HZ / 1000) * SHIFT_HOLD_MS;
	localparam int unsigned LOAD_WINDOW_S = 10; // load averaging window, s
	localparam int unsigned LOAD_SAMPLES_LG = 10; // log2 samples per window
	localparam int unsigned LOAD_TICK_CYC =
		(CLK_HZ * LOAD_WINDOW_S) >> LOAD_SAMPLES_LG;
	// monitor items
	localparam int unsigned ITEM_COUNT = 16; // selectable items
	localparam logic [3:0] IDX_SPEED = 4'h0; // actual speed
	localparam logic [3:0] IDX_SPDREF = 4'h1; // input speed reference
	localparam logic [3:0] IDX_FORCE = 4'h2; // internal force reference
	localparam logic [3:0] IDX_ANG1 = 4'h3; // pulses from zero mark
	localparam logic [3:0] IDX_ANG2 = 4'h4; // degrees from phase U zero
	localparam logic [3:0] IDX_INMON = 4'h5; // input terminal monitor
	localparam logic [3:0] IDX_OUTMON = 4'h6; // output terminal monitor
	localparam logic [3:0] IDX_PULSPD = 4'h7; // reference pulse speed
	localparam logic [3:0] IDX_POSERR = 4'h8; // position error counter
	localparam logic [3:0] IDX_LOAD = 4'h9; // accumulated load rate
	localparam logic [3:0] IDX_REGEN = 4'hA; // regenerative load rate
	localparam logic [3:0] IDX_BRAKE = 4'hB; // braking resistor power
	localparam logic [3:0] IDX_REFCNT = 4'hC; // reference pulse counter
	localparam logic [3:0] IDX_FBCNT = 4'hD; // feedback pulse counter
	localparam logic [3:0] IDX_SPDLIM = 4'hE; // speed limit / dividing ratio
	localparam logic [3:0] IDX_HALL = 4'hF; // hall pattern
	localparam logic [11:0] CODE_SPDLIM = 12'h010; // item code of speed limit
	localparam logic [11:0] CODE_HALL = 12'h011; // item code of hall pattern
	// key bit positions
	localparam int unsigned KEY_COUNT = 5;
	localparam int unsigned KEY_MODE = 0;
	localparam int unsigned KEY_UP = 1;
	localparam int unsigned KEY_DOWN = 2;
	localparam int unsigned KEY_ENTER = 3;
	localparam int unsigned KEY_SHIFT = 4;
	// terminal positions on the output monitor
	localparam int unsigned TERM_COUNT = 7;
	localparam int unsigned OUT_POS_ALARM = 0; // alarm_output
	localparam int unsigned OUT_POS_ALCODE0 = 4; // alarm_code_bit0
	localparam int unsigned OUT_POS_ALCODE2 = 6; // alarm_code_bit2
	// register map
	localparam logic [7:0] REG_CTRL = 8'h00; // panel control
	localparam logic [7:0] REG_STATUS = 8'h04; // panel state
	localparam logic [7:0] REG_DISP = 8'h08; // shown value and code
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int unsigned CTRL_LOCK_BIT = 0; // ignore panel keys
	// display format
	typedef enum logic [1:0] {
		SVMON_FMT_CODE = 2'b00, // item number shown
		SVMON_FMT_DEC = 2'b01, // decimal value
		SVMON_FMT_HEX = 2'b10, // hexadecimal value
		SVMON_FMT_SEG = 2'b11 // terminal segment pattern
	} svmon_fmt_t;
	// panel states
	typedef enum logic [1:0] {
		SVMON_ST_OFF = 2'b00, // another panel mode owns the display
		SVMON_ST_NUM = 2'b01, // item number shown
		SVMON_ST_VAL = 2'b10 // item value shown
	} svmon_state_t;
endpackage

// >>> testbench/svmon_operator.sv
// svmon_operator: behavioural panel operator pressing keys
`timescale 1ns/10ps
`default_nettype none
module svmon_operator (
	input wire logic mclk, // panel clock
	output var logic [4:0] key_pin // keys, high while pressed
);
	initial key_pin = 5'h00; // all keys up at start
	// hold a key n cycles, release it, then let the action settle;
	// the release keeps every press a fresh edge for the detector
	task automatic press(input int k, input int n);
		@(posedge mclk);
		key_pin[k] <= 1'b1;
		repeat (n) @(posedge mclk);
		key_pin[k] <= 1'b0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
	endtask
endmodule // svmon_operator
`default_nettype wire

// >>> testbench/svmon_panel_props.sv
// svmon_panel_props: port assertions for the monitor panel
`timescale 1ns/10ps
`default_nettype none
module svmon_panel_props #(
	parameter int unsigned HOLD_CYC = 20, // shift hold cycles
	parameter int unsigned LOAD_TICK = 4 // load sample spacing
) (
	input wire logic mclk, // panel clock
	input wire logic rst_n, // reset, low active
	input wire logic speed_mode, // speed control
	input wire logic position_mode, // position control
	input wire logic scale_zero_ok, // zero mark present
	input wire logic [15:0] speed_act, // actual speed
	input wire logic [6:0] out_term_lvl, // output levels
	input wire logic [11:0] disp_code, // shown code
	input wire logic [15:0] disp_data, // shown value
	input wire logic [1:0] disp_fmt, // shown format
	input wire logic disp_valid, // item valid
	input wire logic disp_upper, // upper half shown
	input wire logic [6:0] seg_top, // top segments
	input wire logic [6:0] seg_bot // bottom segments
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// value view held three cycles with its cause still, so latency is over
	sequence s_view(ok, x);
		(ok && disp_fmt != 2'b00 && $stable(x))[*3];
	endsequence
	property p_code_set;
		disp_code <= 12'h00D || disp_code inside {12'h010, 12'h011};
	endproperty
	a_code_set: assert property (p_code_set)
		else $error("item code outside the selectable set");
	property p_spd_valid;
		s_view(disp_code == 12'h001, speed_mode) |-> disp_valid == speed_mode;
	endproperty
	a_spd_valid: assert property (p_spd_valid)
		else $error("speed reference validity wrong");
	property p_pos_valid;
		s_view(disp_code inside {12'h007, 12'h008, 12'h00C}, position_mode)
			|-> disp_valid == position_mode;
	endproperty
	a_pos_valid: assert property (p_pos_valid)
		else $error("position item validity wrong");
	property p_ang_valid;
		s_view(disp_code == 12'h003, scale_zero_ok)
			|-> disp_valid == scale_zero_ok;
	endproperty
	a_ang_valid: assert property (p_ang_valid)
		else $error("angle item validity wrong");
	property p_live;
		s_view(disp_code == 12'h000, speed_act) |-> disp_data == speed_act;
	endproperty
	a_live: assert property (p_live)
		else $error("speed value not refreshed");
	property p_hex;
		disp_fmt == 2'b10 |-> disp_code inside {12'h00C, 12'h00D};
	endproperty
	a_hex: assert property (p_hex)
		else $error("hex format on a non-counter item");
	property p_dec;
		disp_code == 12'h003 && disp_fmt != 2'b00 |-> disp_fmt == 2'b01;
	endproperty
	a_dec: assert property (p_dec)
		else $error("angle count not decimal");
	property p_upper;
		disp_upper |-> disp_code inside {12'h003, 12'h00C, 12'h00D};
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper half flag on a 16-bit item");
	property p_out_seg;
		s_view(disp_code == 12'h006, out_term_lvl)
			|-> seg_bot == ~out_term_lvl && seg_top == out_term_lvl;
	endproperty
	a_out_seg: assert property (p_out_seg)
		else $error("output segments do not follow levels");
	property p_seg_excl;
		disp_fmt == 2'b11 && $past(disp_fmt) == 2'b11
			|-> (seg_top ^ seg_bot) == 7'h7F;
	endproperty
	a_seg_excl: assert property (p_seg_excl)
		else $error("segment position not exactly one of top or bottom");
endmodule // svmon_panel_props
bind svmon_panel svmon_panel_props #(.HOLD_CYC(HOLD_CYC),
	.LOAD_TICK(LOAD_TICK)) svmon_panel_props_i (.mclk, .rst_n,
	.speed_mode, .position_mode, .scale_zero_ok, .speed_act,
	.out_term_lvl, .disp_code, .disp_data, .disp_fmt, .disp_valid,
	.disp_upper, .seg_top, .seg_bot);
`default_nettype wire

// >>> testbench/svmon_panel_tb_top.sv
// svmon_panel_tb_top: self-checking bench for the monitor panel
`timescale 1ns/10ps
`default_nettype none
module svmon_panel_tb_top;
	logic mclk = 1'b0; // panel clock
	logic rst_n = 1'b0; // reset, low active
	logic ph = 1'b0; // picks one of two input value sets
	logic [7:0] reg_addr = 8'h00; // register address
	logic [31:0] reg_wdata = 32'h0; // register write data
	logic reg_wr = 1'b0; // write strobe
	logic reg_rd = 1'b0; // read strobe
	logic [31:0] rdat, w, ed; // read word, item value, expected
	logic [1:0] ef; // expected format
	logic [4:0] key_pin; // keys from the operator
	logic [31:0] reg_rdata;
	logic mon_active, disp_valid, disp_upper;
	logic [11:0] disp_code;
	logic [15:0] disp_data;
	logic [1:0] disp_fmt;
	logic [6:0] seg_top, seg_bot;
	int fail_count = 0;
	int cmp_count = 0;
	// live drive values; ph flips all but the three load rates while monitor mode runs
	wire logic speed_mode = ph;
	wire logic position_mode = ~ph;
	wire logic scale_zero_ok = ph;
	wire logic [6:0] in_term_on = {7{ph}} ^ 7'h55;
	wire logic [6:0] out_term_lvl = {7{ph}} ^ 7'h71;
	wire logic [15:0] speed_act = {16{ph}} ^ 16'h05DC;
	wire logic [15:0] speed_ref = {16{ph}} ^ 16'h0321;
	wire logic [15:0] force_ref = {16{ph}} ^ 16'h0064;
	wire logic [31:0] angle_pulses = {32{ph}} ^ 32'h0001_2345;
	wire logic [15:0] angle_deg = {16{ph}} ^ 16'h00B4;
	wire logic [15:0] pulse_speed = {16{ph}} ^ 16'h0777;
	wire logic [15:0] pos_error = {16{ph}} ^ 16'h0042;
	wire logic [7:0] load_pct = 8'h3C; // constant so the mean is known
	wire logic [7:0] regen_pct = 8'h14;
	wire logic [7:0] brake_pct = 8'h07;
	wire logic [31:0] ref_count = {32{ph}} ^ 32'hDEAD_0BEE;
	wire logic [31:0] fb_count = {32{ph}} ^ 32'h1357_9BDF;
	wire logic [15:0] speed_limit = {16{ph}} ^ 16'h0050;
	wire logic [15:0] divide_ratio = {16{ph}} ^ 16'h0020;
	wire logic [2:0] hall_pattern = {3{ph}} ^ 3'h5;
	always #50 mclk = ~mclk; // 10 MHz
	svmon_panel #(.HOLD_CYC(20), .LOAD_TICK(4)) svmon_panel_i (.mclk,
		.rst_n, .key_pin, .in_term_on, .out_term_lvl, .speed_mode,
		.position_mode, .scale_zero_ok, .speed_act, .speed_ref,
		.force_ref, .angle_pulses, .angle_deg, .pulse_speed, .pos_error,
		.load_pct, .regen_pct, .brake_pct, .ref_count, .fb_count,
		.speed_limit, .divide_ratio, .hall_pattern, .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mon_active,
		.disp_code, .disp_data, .disp_fmt, .disp_valid, .disp_upper,
		.seg_top, .seg_bot);
	svmon_operator svmon_operator_i (.mclk, .key_pin);
	// compare one value and count it
	task automatic chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		rdat = reg_rdata;
	endtask
	task automatic push(input int k);
		svmon_operator_i.press(k, 4);
	endtask
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(negedge mclk);
		chk("idle", 32'(mon_active), 32'h0);
		rd(8'h00);
		chk("ctrl", rdat, 32'h0);
		rd(8'h0C);
		chk("unmapped", rdat, 32'h0);
		push(svmon_pkg::KEY_MODE);
		chk("active", 32'(mon_active), 32'h1);
		wr(8'h04, 32'hFFFF_FFFF); // read-only, ignored
		rd(8'h04);
		chk("status", rdat & 32'h7F, 32'h20);
		wr(8'h00, 32'h1); // lock keys
		push(svmon_pkg::KEY_UP);
		chk("locked", 32'(disp_code), 32'h0);
		rd(8'h00);
		chk("ctrl", rdat, 32'h1);
		wr(8'h00, 32'h0);
		repeat (9000) @(posedge mclk); // two load windows close
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			ph <= 1'(p);
			@(negedge mclk);
			for (int i = 0; i < 16; i++) begin
				chk("code", 32'(disp_code), 32'(i < 14 ? i : i + 2));
				push(svmon_pkg::KEY_ENTER);
				case (i)
					0: w = 32'(speed_act);
					1: w = 32'(speed_ref);
					2: w = 32'(force_ref);
					3: w = angle_pulses;
					4: w = 32'(angle_deg);
					7: w = 32'(pulse_speed);
					8: w = 32'(pos_error);
					9: w = 32'(load_pct);
					10: w = 32'(regen_pct);
					11: w = 32'(brake_pct);
					12: w = ref_count;
					13: w = fb_count;
					14: w = 32'(speed_limit);
					15: w = 32'(hall_pattern);
					default: w = 32'h0;
				endcase
				ed = (i inside {3, 12, 13}) ? {16'h0, w[31:16]} : w;
				ef = (i inside {5, 6}) ? 2'b11 : (i inside {12, 13}) ? 2'b10 : 2'b01;
				if (!(i inside {5, 6}))
					chk("data", 32'(disp_data), ed);
				if (i < 14)
					chk("fmt", 32'(disp_fmt), 32'(ef));
				chk("valid", 32'(disp_valid), 32'((i == 1) ? ph : (i == 3) ? ph :
					(i inside {7, 8, 12}) ? !ph : 1'b1));
				if (i == 5) begin
					chk("in_top", 32'(seg_top), {25'h0, ~in_term_on});
					chk("in_bot", 32'(seg_bot), 32'(in_term_on));
				end
				if (i == 6)
					chk("out_bot", 32'(seg_bot), {25'h0, ~out_term_lvl});
				if (i inside {3, 12, 13}) begin
					chk("upper", 32'(disp_upper), 32'h1);
					push(svmon_pkg::KEY_UP);
					chk("lower", 32'(disp_data), {16'h0, w[15:0]});
				end
				if (i == 14) begin
					push(svmon_pkg::KEY_MODE);
					chk("ratio", 32'(disp_data), 32'(divide_ratio));
					push(svmon_pkg::KEY_MODE);
				end
				push(svmon_pkg::KEY_ENTER);
				chk("back", 32'(disp_fmt), 32'h0);
				push(svmon_pkg::KEY_UP);
			end
			chk("wrap", 32'(disp_code), 32'h0);
		end
		svmon_operator_i.press(svmon_pkg::KEY_SHIFT, 30);
		chk("hold_in", 32'(disp_fmt), 32'h1);
		svmon_operator_i.press(svmon_pkg::KEY_SHIFT, 30);
		chk("hold_out", 32'(disp_fmt), 32'h0);
		push(svmon_pkg::KEY_DOWN);
		chk("down", 32'(disp_code), 32'h011);
		wrap_up();
	end
endmodule // svmon_panel_tb_top
`default_nettype wire
